// File: hw/bbr_pkg.sv
// Package for the banked gain-control and synthesizer loop register set.
// Assumes an 8-bit register port with a 7-bit address and single-cycle strobes.
package bbr_pkg;

	// ********************************
	// Offsets
	// ********************************
	localparam logic [6:0] BBR_ADDR_OPMODE    = 7'h01;
	localparam logic [6:0] BBR_ADDR_FLOOR     = 7'h61;
	localparam logic [6:0] BBR_ADDR_THRESH1   = 7'h62;
	localparam logic [6:0] BBR_ADDR_THRESH23  = 7'h63;
	localparam logic [6:0] BBR_ADDR_THRESH45  = 7'h64;
	localparam logic [6:0] BBR_ADDR_SYNTH     = 7'h70;
	localparam logic [6:0] BBR_ADDR_BANK_LO   = 7'h61;
	localparam logic [6:0] BBR_ADDR_BANK_HI   = 7'h73;

	// ********************************
	// Field positions
	// ********************************
	localparam int BBR_BAND_SELECT_BIT = 3;
	localparam int BBR_FLOOR_W         = 6;
	localparam int BBR_THRESH1_W       = 5;
	localparam int BBR_NIBBLE_W        = 4;
	localparam int BBR_HI_NIBBLE_LSB   = 4;
	localparam int BBR_SYNTH_BW_LSB    = 6;
	localparam int BBR_SYNTH_BW_W      = 2;
	localparam int BBR_SYNTH_RSV_W     = 6;

	// ********************************
	// Reset values
	// ********************************
	localparam logic       BBR_RST_BAND_SELECT = 1'h1;
	localparam logic [5:0] BBR_RST_FLOOR_LOW   = 6'h19;
	localparam logic [5:0] BBR_RST_FLOOR_HIGH  = 6'h1C;
	localparam logic [4:0] BBR_RST_TH1_LOW     = 5'h0C;
	localparam logic [4:0] BBR_RST_TH1_HIGH    = 5'h0E;
	localparam logic [3:0] BBR_RST_TH2_LOW     = 4'h4;
	localparam logic [3:0] BBR_RST_TH2_HIGH    = 4'h5;
	localparam logic [3:0] BBR_RST_TH3         = 4'hB;
	localparam logic [3:0] BBR_RST_TH4         = 4'hC;
	localparam logic [3:0] BBR_RST_TH5         = 4'hC;
	localparam logic [1:0] BBR_RST_SYNTH_BW    = 2'h3;
	localparam logic [5:0] BBR_RST_SYNTH_RSV   = 6'h10;

	// ********************************
	// Types
	// ********************************
	typedef struct packed {
		logic [5:0] floor_offset;
		logic [4:0] threshold_first;
		logic [3:0] threshold_second;
		logic [3:0] threshold_third;
		logic [3:0] threshold_fourth;
		logic [3:0] threshold_fifth;
		logic [1:0] synth_bw;
		logic [5:0] synth_rsv;
	} bbr_bank_s;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bbr_req_s;

endpackage

// File: hw/bbr_bank.sv
// One band copy of the banked settings.
// Assumes the parent decodes the band and gives one write strobe per copy.
`timescale 1ns/100ps
module bbr_bank
	import bbr_pkg::*;
#(
	parameter bbr_bank_s RESET_VALUE = '0
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic [6:0] addr,
	input  wire logic [7:0] wdata,
	output bbr_bank_s       bank
);

	// ********************************
	// State
	// ********************************
	bbr_bank_s next_bank;

	always_comb begin
		next_bank = bank;
		if (wr_en) begin
			if (addr == BBR_ADDR_FLOOR) begin
				next_bank.floor_offset = wdata[BBR_FLOOR_W-1:0];
			end else if (addr == BBR_ADDR_THRESH1) begin
				next_bank.threshold_first = wdata[BBR_THRESH1_W-1:0];
			end else if (addr == BBR_ADDR_THRESH23) begin
				next_bank.threshold_second = wdata[7:BBR_HI_NIBBLE_LSB];
				next_bank.threshold_third  = wdata[BBR_NIBBLE_W-1:0];
			end else if (addr == BBR_ADDR_THRESH45) begin
				next_bank.threshold_fourth = wdata[7:BBR_HI_NIBBLE_LSB];
				next_bank.threshold_fifth  = wdata[BBR_NIBBLE_W-1:0];
			end else if (addr == BBR_ADDR_SYNTH) begin
				next_bank.synth_bw  = wdata[7:BBR_SYNTH_BW_LSB];
				next_bank.synth_rsv = wdata[BBR_SYNTH_RSV_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bank <= RESET_VALUE;
		end else begin
			bank <= next_bank;
		end
	end

endmodule // bbr_bank

// File: hw/bbr_regs.sv
// Banked gain-control and synthesizer loop registers, two band copies.
// Assumes one 200 MHz clock and a simple strobe port driven on that clock.
//
// Summary of operation
// - Offsets 0x61 to 0x73 hold separate low-band and high-band copies.
// - Both copies keep values across band switches; writes touch one copy.
// - Band-select bit 3 of operating mode register steers banked accesses.
// - Band-select resets to 1, low-band copy selected.
// - Band-select 0 exposes high-band copy, 1 exposes low-band copy.
// - Floor offset, bits 5-0 at 0x61, resets 0x19 low, 0x1C high.
// - Floor offset adds to noise floor plus 8 dB margin as reference.
// - First threshold, bits 4-0 at 0x62, resets 0x0C low, 0x0E high.
// - Second threshold, bits 7-4 at 0x63, resets 0x4 low, 0x5 high.
// - Third threshold, bits 3-0 at 0x63, resets 0xB both.
// - Fourth threshold, bits 7-4 at 0x64, resets 0xC both.
// - Fifth threshold, bits 3-0 at 0x64, resets 0xC both.
// - Loop bandwidth bits 7-6 at 0x70, reset 3; 75 to 300 kHz.
// - Bits 5-0 at 0x70 are spare storage resetting to 0x10.
`timescale 1ns/100ps
module bbr_regs
	import bbr_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [6:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            band_select_low,
	output logic      [5:0] gain_floor_offset,
	output logic      [4:0] gain_threshold_first,
	output logic      [3:0] gain_threshold_second,
	output logic      [3:0] gain_threshold_third,
	output logic      [3:0] gain_threshold_fourth,
	output logic      [3:0] gain_threshold_fifth,
	output logic      [1:0] synth_loop_bandwidth
);

	// ********************************
	// Reset images of each copy
	// ********************************
	localparam bbr_bank_s BANK_LOW_RST = '{
		floor_offset:     BBR_RST_FLOOR_LOW,
		threshold_first:  BBR_RST_TH1_LOW,
		threshold_second: BBR_RST_TH2_LOW,
		threshold_third:  BBR_RST_TH3,
		threshold_fourth: BBR_RST_TH4,
		threshold_fifth:  BBR_RST_TH5,
		synth_bw:         BBR_RST_SYNTH_BW,
		synth_rsv:        BBR_RST_SYNTH_RSV
	};
	localparam bbr_bank_s BANK_HIGH_RST = '{
		floor_offset:     BBR_RST_FLOOR_HIGH,
		threshold_first:  BBR_RST_TH1_HIGH,
		threshold_second: BBR_RST_TH2_HIGH,
		threshold_third:  BBR_RST_TH3,
		threshold_fourth: BBR_RST_TH4,
		threshold_fifth:  BBR_RST_TH5,
		synth_bw:         BBR_RST_SYNTH_BW,
		synth_rsv:        BBR_RST_SYNTH_RSV
	};

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		logic       band_select;
		logic [7:0] rdata;
	} bbr_state_s;

	bbr_state_s state;
	bbr_state_s next_state;
	bbr_req_s   req;
	bbr_bank_s  bank_low;
	bbr_bank_s  bank_high;
	bbr_bank_s  bank_sel;
	logic       in_banked;
	logic       wr_low;
	logic       wr_high;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	assign in_banked = (req.addr >= BBR_ADDR_BANK_LO) && (req.addr <= BBR_ADDR_BANK_HI);

	assign wr_low  = req.wr && in_banked && state.band_select;
	assign wr_high = req.wr && in_banked && !state.band_select;

	// ********************************
	// Band copies
	// ********************************
	bbr_bank #(
		.RESET_VALUE (BANK_LOW_RST)
	) u_bank_low (
		.clk_sys (clk_sys),
		.rst     (rst),
		.wr_en   (wr_low),
		.addr    (req.addr),
		.wdata   (req.wdata),
		.bank    (bank_low)
	);

	bbr_bank #(
		.RESET_VALUE (BANK_HIGH_RST)
	) u_bank_high (
		.clk_sys (clk_sys),
		.rst     (rst),
		.wr_en   (wr_high),
		.addr    (req.addr),
		.wdata   (req.wdata),
		.bank    (bank_high)
	);

	// selected copy for reads and outputs
	assign bank_sel = state.band_select ? bank_low : bank_high;

	// ********************************
	// Register port
	// ********************************
	always_comb begin
		next_state = state;
		next_state.rdata = 8'h00;
		// band bit lives in operating mode
		if (req.wr && req.addr == BBR_ADDR_OPMODE) begin
			next_state.band_select = req.wdata[BBR_BAND_SELECT_BIT];
		end
		if (req.rd) begin
			if (req.addr == BBR_ADDR_OPMODE) begin
				next_state.rdata[BBR_BAND_SELECT_BIT] = state.band_select;
			end else if (req.addr == BBR_ADDR_FLOOR) begin
				next_state.rdata[BBR_FLOOR_W-1:0] = bank_sel.floor_offset;
			end else if (req.addr == BBR_ADDR_THRESH1) begin
				next_state.rdata[BBR_THRESH1_W-1:0] = bank_sel.threshold_first;
			end else if (req.addr == BBR_ADDR_THRESH23) begin
				next_state.rdata = {bank_sel.threshold_second, bank_sel.threshold_third};
			end else if (req.addr == BBR_ADDR_THRESH45) begin
				next_state.rdata = {bank_sel.threshold_fourth, bank_sel.threshold_fifth};
			end else if (req.addr == BBR_ADDR_SYNTH) begin
				next_state.rdata = {bank_sel.synth_bw, bank_sel.synth_rsv};
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= '{band_select: BBR_RST_BAND_SELECT, rdata: 8'h00};
		end else begin
			state <= next_state;
		end
	end

	// ********************************
	// Outputs to the analog side
	// ********************************
	// raw codes; dB and kHz mapping is analog
	assign reg_rdata             = state.rdata;
	assign band_select_low       = state.band_select;
	assign gain_floor_offset     = bank_sel.floor_offset;
	assign gain_threshold_first  = bank_sel.threshold_first;
	assign gain_threshold_second = bank_sel.threshold_second;
	assign gain_threshold_third  = bank_sel.threshold_third;
	assign gain_threshold_fourth = bank_sel.threshold_fourth;
	assign gain_threshold_fifth  = bank_sel.threshold_fifth;
	assign synth_loop_bandwidth  = bank_sel.synth_bw;

	// ********************************
	// Checks
	// ********************************
	sequence s_write_high_floor;
		reg_wr && reg_addr == BBR_ADDR_FLOOR && !band_select_low;
	endsequence

	a_low_copy_kept: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && in_banked && !band_select_low) |=> $stable(bank_low))
		else $error("low copy changed by high-band write");
	a_high_copy_kept: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && in_banked && band_select_low) |=> $stable(bank_high))
		else $error("high copy changed by low-band write");
	a_band_bit_write: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == BBR_ADDR_OPMODE) |=> band_select_low == $past(reg_wdata[3]))
		else $error("band bit not taken from write");
	a_band_reset_low: assert property (@(posedge clk_sys)
		$fell(rst) |-> band_select_low)
		else $error("band bit not one after reset");
	a_high_floor_path: assert property (@(posedge clk_sys) disable iff (rst)
		s_write_high_floor ##1 (reg_rd && reg_addr == BBR_ADDR_FLOOR && !band_select_low)
		|=> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)})
		else $error("high floor readback wrong");
	a_floor_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == BBR_ADDR_FLOOR) |=> reg_rdata[7:6] == 2'h0)
		else $error("floor upper bits not zero");
	a_thresh1_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == BBR_ADDR_THRESH1) |=> reg_rdata[7:5] == 3'h0)
		else $error("threshold one upper bits not zero");
	a_gap_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && in_banked && reg_addr > BBR_ADDR_THRESH45 && reg_addr != BBR_ADDR_SYNTH)
		|=> reg_rdata == 8'h00)
		else $error("undefined banked offset not zero");
	a_synth_readback: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == BBR_ADDR_SYNTH) |=> reg_rdata[7:6] == $past(synth_loop_bandwidth))
		else $error("loop bandwidth readback wrong");

	// ********************************
	// Reset checks
	// ********************************
	// Copies are sampled ahead of any write taken on the release edge
	sequence s_reset_done;
		$fell(rst);
	endsequence

	a_floor_reset_low: assert property (@(posedge clk_sys)
		s_reset_done |-> bank_low.floor_offset == BBR_RST_FLOOR_LOW)
		else $error("low floor reset value wrong");
	a_floor_reset_high: assert property (@(posedge clk_sys)
		s_reset_done |-> bank_high.floor_offset == BBR_RST_FLOOR_HIGH)
		else $error("high floor reset value wrong");
	a_th1_reset_copies: assert property (@(posedge clk_sys)
		s_reset_done |-> bank_low.threshold_first == BBR_RST_TH1_LOW
			&& bank_high.threshold_first == BBR_RST_TH1_HIGH)
		else $error("first threshold reset value wrong");
	a_th2_reset_copies: assert property (@(posedge clk_sys)
		s_reset_done |-> bank_low.threshold_second == BBR_RST_TH2_LOW
			&& bank_high.threshold_second == BBR_RST_TH2_HIGH)
		else $error("second threshold reset value wrong");
	a_th3_reset_copies: assert property (@(posedge clk_sys)
		s_reset_done |-> bank_low.threshold_third == BBR_RST_TH3
			&& bank_high.threshold_third == BBR_RST_TH3)
		else $error("third threshold reset value wrong");
	a_th4_reset_copies: assert property (@(posedge clk_sys)
		s_reset_done |-> bank_low.threshold_fourth == BBR_RST_TH4
			&& bank_high.threshold_fourth == BBR_RST_TH4)
		else $error("fourth threshold reset value wrong");
	a_th5_reset_copies: assert property (@(posedge clk_sys)
		s_reset_done |-> bank_low.threshold_fifth == BBR_RST_TH5
			&& bank_high.threshold_fifth == BBR_RST_TH5)
		else $error("fifth threshold reset value wrong");
	a_bw_reset_copies: assert property (@(posedge clk_sys)
		s_reset_done |-> bank_low.synth_bw == BBR_RST_SYNTH_BW
			&& bank_high.synth_bw == BBR_RST_SYNTH_BW)
		else $error("loop bandwidth reset value wrong");
	a_spare_reset_copies: assert property (@(posedge clk_sys)
		s_reset_done |-> bank_low.synth_rsv == BBR_RST_SYNTH_RSV
			&& bank_high.synth_rsv == BBR_RST_SYNTH_RSV)
		else $error("spare bits reset value wrong");

	// ********************************
	// Write steering checks
	// ********************************
	sequence s_write_low_floor;
		reg_wr && reg_addr == BBR_ADDR_FLOOR && band_select_low;
	endsequence
	sequence s_band_to_high;
		reg_wr && reg_addr == BBR_ADDR_OPMODE && !reg_wdata[BBR_BAND_SELECT_BIT];
	endsequence
	sequence s_band_to_low;
		reg_wr && reg_addr == BBR_ADDR_OPMODE && reg_wdata[BBR_BAND_SELECT_BIT];
	endsequence

	a_low_floor_write: assert property (@(posedge clk_sys) disable iff (rst)
		s_write_low_floor |=> bank_low.floor_offset == $past(reg_wdata[BBR_FLOOR_W-1:0]))
		else $error("low floor write lost");
	a_high_floor_write: assert property (@(posedge clk_sys) disable iff (rst)
		s_write_high_floor |=> bank_high.floor_offset == $past(reg_wdata[BBR_FLOOR_W-1:0]))
		else $error("high floor write lost");
	a_th1_write: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == BBR_ADDR_THRESH1)
		|=> gain_threshold_first == $past(reg_wdata[BBR_THRESH1_W-1:0]))
		else $error("first threshold write lost");
	a_th23_write: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == BBR_ADDR_THRESH23)
		|=> gain_threshold_second == $past(reg_wdata[7:BBR_HI_NIBBLE_LSB])
			&& gain_threshold_third == $past(reg_wdata[BBR_NIBBLE_W-1:0]))
		else $error("second or third threshold write lost");
	a_th45_write: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == BBR_ADDR_THRESH45)
		|=> gain_threshold_fourth == $past(reg_wdata[7:BBR_HI_NIBBLE_LSB])
			&& gain_threshold_fifth == $past(reg_wdata[BBR_NIBBLE_W-1:0]))
		else $error("fourth or fifth threshold write lost");
	a_synth_write: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == BBR_ADDR_SYNTH)
		|=> synth_loop_bandwidth == $past(reg_wdata[7:BBR_SYNTH_BW_LSB]))
		else $error("loop bandwidth write lost");
	a_spare_write: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == BBR_ADDR_SYNTH && band_select_low)
		|=> bank_low.synth_rsv == $past(reg_wdata[BBR_SYNTH_RSV_W-1:0]))
		else $error("spare bits write lost");
	a_gap_write_ignored: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && in_banked && reg_addr > BBR_ADDR_THRESH45 && reg_addr != BBR_ADDR_SYNTH)
		|=> $stable(bank_low) && $stable(bank_high))
		else $error("undefined banked write changed a copy");
	a_band_keeps_copies: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == BBR_ADDR_OPMODE) |=> $stable(bank_low) && $stable(bank_high))
		else $error("band switch changed a copy");

	// ********************************
	// Band switch checks
	// ********************************
	// Outputs follow the band bit with no extra cycle
	a_switch_to_high: assert property (@(posedge clk_sys) disable iff (rst)
		s_band_to_high |=> !band_select_low
			&& gain_floor_offset == $past(bank_high.floor_offset))
		else $error("high copy not shown after switch");
	a_switch_to_low: assert property (@(posedge clk_sys) disable iff (rst)
		s_band_to_low |=> band_select_low
			&& synth_loop_bandwidth == $past(bank_low.synth_bw))
		else $error("low copy not shown after switch");

	// ********************************
	// Readback checks
	// ********************************
	a_opmode_readback: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == BBR_ADDR_OPMODE) |=> reg_rdata == {4'h0, $past(band_select_low), 3'h0})
		else $error("operating mode readback wrong");
	a_floor_readback: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == BBR_ADDR_FLOOR) |=> reg_rdata == {2'h0, $past(gain_floor_offset)})
		else $error("floor readback wrong");
	a_th1_readback: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == BBR_ADDR_THRESH1) |=> reg_rdata == {3'h0, $past(gain_threshold_first)})
		else $error("first threshold readback wrong");
	a_th23_readback: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == BBR_ADDR_THRESH23)
		|=> reg_rdata[7:4] == $past(gain_threshold_second)
			&& reg_rdata[3:0] == $past(gain_threshold_third))
		else $error("second and third threshold readback wrong");
	a_th45_readback: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == BBR_ADDR_THRESH45)
		|=> reg_rdata[7:4] == $past(gain_threshold_fourth)
			&& reg_rdata[3:0] == $past(gain_threshold_fifth))
		else $error("fourth and fifth threshold readback wrong");
	a_spare_readback: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == BBR_ADDR_SYNTH && band_select_low)
		|=> reg_rdata[5:0] == $past(bank_low.synth_rsv))
		else $error("spare bits readback wrong");

	// ********************************
	// Selected copy checks
	// ********************************
	a_outputs_low: assert property (@(posedge clk_sys) disable iff (rst)
		band_select_low |-> gain_floor_offset == bank_low.floor_offset
			&& gain_threshold_first == bank_low.threshold_first
			&& gain_threshold_second == bank_low.threshold_second
			&& gain_threshold_third == bank_low.threshold_third
			&& gain_threshold_fourth == bank_low.threshold_fourth
			&& gain_threshold_fifth == bank_low.threshold_fifth
			&& synth_loop_bandwidth == bank_low.synth_bw)
		else $error("outputs do not follow low copy");
	a_outputs_high: assert property (@(posedge clk_sys) disable iff (rst)
		!band_select_low |-> gain_floor_offset == bank_high.floor_offset
			&& gain_threshold_first == bank_high.threshold_first
			&& gain_threshold_second == bank_high.threshold_second
			&& gain_threshold_third == bank_high.threshold_third
			&& gain_threshold_fourth == bank_high.threshold_fourth
			&& gain_threshold_fifth == bank_high.threshold_fifth
			&& synth_loop_bandwidth == bank_high.synth_bw)
		else $error("outputs do not follow high copy");

endmodule // bbr_regs

// File: test/test_bbr_regs.sv
// Self-checking bench for the banked gain-control register set.
// Assumes bbr_regs alone, driven over its strobe port on clk_sys.
`timescale 1ns/100ps
module test_bbr_regs
	import bbr_pkg::*;
;
	// ********************************
	// Signals and design
	// ********************************
	logic       clk_sys   = 1'b0;
	logic       rst       = 1'b1;
	logic [6:0] reg_addr  = 7'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr    = 1'b0;
	logic       reg_rd    = 1'b0;
	logic [7:0] reg_rdata;
	logic       band_select_low;
	logic [5:0] gain_floor_offset;
	logic [4:0] gain_threshold_first;
	logic [3:0] gain_threshold_second;
	logic [3:0] gain_threshold_third;
	logic [3:0] gain_threshold_fourth;
	logic [3:0] gain_threshold_fifth;
	logic [1:0] synth_loop_bandwidth;
	int         err_count = 0;
	int         cmp_count = 0;
	logic [6:0] adr    [5] = '{7'h61, 7'h62, 7'h63, 7'h64, 7'h70};
	logic [7:0] lo_def [5] = '{8'h19, 8'h0C, 8'h4B, 8'hCC, 8'hD0};
	logic [7:0] hi_def [5] = '{8'h1C, 8'h0E, 8'h5B, 8'hCC, 8'hD0};
	logic [7:0] hi_w   [5] = '{8'hEA, 8'hF5, 8'hA5, 8'h5A, 8'h47};
	logic [7:0] hi_rd  [5] = '{8'h2A, 8'h15, 8'hA5, 8'h5A, 8'h47};
	logic [6:0] gap    [4] = '{7'h65, 7'h6F, 7'h71, 7'h73};

	bbr_regs i_bbr_regs (
		.clk_sys              (clk_sys),
		.rst                  (rst),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_rdata            (reg_rdata),
		.band_select_low      (band_select_low),
		.gain_floor_offset    (gain_floor_offset),
		.gain_threshold_first (gain_threshold_first),
		.gain_threshold_second(gain_threshold_second),
		.gain_threshold_third (gain_threshold_third),
		.gain_threshold_fourth(gain_threshold_fourth),
		.gain_threshold_fifth (gain_threshold_fifth),
		.synth_loop_bandwidth (synth_loop_bandwidth)
	);

	always begin
		#2.5 clk_sys = ~clk_sys;
	end

	// ********************************
	// Port tasks
	// ********************************
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin err_count++; \
	$display("[ERR] %0t got %0h expected %0h", $time, act, exp); end end

	// Write strobe left high so a following access is back to back
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_rd    <= 1'b0;
		reg_addr  <= a;
		reg_wdata <= d;
	endtask

	task automatic idle();
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask

	// Data stand only the cycle after the strobe, then zero
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_wr   <= 1'b0;
		reg_rd   <= 1'b1;
		reg_addr <= a;
		idle();
		`CHK(reg_rdata, e)
		idle();
		`CHK(reg_rdata, 8'h00)
	endtask

	task automatic outs(input logic [28:0] e);
		`CHK({gain_floor_offset, gain_threshold_first, gain_threshold_second, gain_threshold_third,
			gain_threshold_fourth, gain_threshold_fifth, synth_loop_bandwidth}, e)
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ********************************
	// Tests
	// ********************************
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		`CHK(band_select_low, 1'b1)
		outs({6'h19, 5'h0C, 4'h4, 4'hB, 4'hC, 4'hC, 2'h3});
		rd(7'h01, 8'h08);
		for (int i = 0; i < 5; i++) rd(adr[i], lo_def[i]);
		wr(7'h01, 8'h00);
		idle();
		`CHK(band_select_low, 1'b0)
		outs({6'h1C, 5'h0E, 4'h5, 4'hB, 4'hC, 4'hC, 2'h3});
		for (int i = 0; i < 5; i++) rd(adr[i], hi_def[i]);
		// Write then read with no gap
		for (int i = 0; i < 5; i++) begin
			wr(adr[i], hi_w[i]);
			rd(adr[i], hi_rd[i]);
		end
		outs({6'h2A, 5'h15, 4'hA, 4'h5, 4'h5, 4'hA, 2'h1});
		wr(7'h01, 8'hFF);
		rd(7'h01, 8'h08);
		for (int i = 0; i < 5; i++) rd(adr[i], lo_def[i]);
		for (int c = 0; c < 4; c++) begin
			wr(7'h70, {c[1:0], 6'h10});
			idle();
			`CHK(synth_loop_bandwidth, c[1:0])
			rd(7'h70, {c[1:0], 6'h10});
		end
		wr(7'h61, 8'hFF);
		rd(7'h61, 8'h3F);
		wr(7'h01, 8'h00);
		for (int i = 0; i < 5; i++) rd(adr[i], hi_rd[i]);
		for (int i = 0; i < 4; i++) begin
			wr(gap[i], 8'hFF);
			rd(gap[i], 8'h00);
		end
		rd(7'h61, 8'h2A);
		// Reset in mid-run restores both copies
		@(posedge clk_sys);
		rst <= 1'b1;
		#1;
		`CHK(band_select_low, 1'b1)
		@(posedge clk_sys);
		rst <= 1'b0;
		rd(7'h61, 8'h19);
		wr(7'h01, 8'h00);
		rd(7'h61, 8'h1C);
		test_done();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		test_done();
	end
endmodule // test_bbr_regs
